// *** inc/vtm_pkg.sv ***
// Constants for the velocity threshold mode select block
// Overview of operation
// - Velocity is the measured time between two successive step pulses.
// - Step interval is always normalised to 256 microsteps per full step.
// - Interval is compared against quiet PWM, high velocity and adaptive thresholds.
// - Comparisons use hysteresis of one sixteenth or one thirty-second.
// - Hysteresis band sits above threshold velocity, i.e. below interval.
// - Current scale is run level while moving, hold level at standstill.
// - Modes switch purely from comparisons, no software action per transition.
// - Standstill flag sets (2^20)-1 clocks after last step pulse.
// - Interval reported in clocks, saturates at (2^20)-1 on overflow or standstill.
// - Adaptive current on, voltage PWM off between high and adaptive thresholds.
// - Hysteresis select bit: 0 gives 1/16, 1 gives 1/32.
`default_nettype none
package vtm_pkg;
	localparam int INTERVAL_W = 20;
	localparam logic [19:0] INTERVAL_MAX = 20'hFFFFF;
	localparam int USTEP_FULL = 256;
	localparam int USTEP_SEL_W = 4;
	localparam int HYST_SHIFT_COARSE = 4;
	localparam int HYST_SHIFT_FINE = 5;
	localparam int CURRENT_W = 5;
	localparam int CLK_MHZ = 125;
endpackage
`default_nettype wire

// *** hw/vtm_velocity_mode.sv ***
// Velocity threshold mode select: step interval measurement and mode decisions
`default_nettype none
module vtm_velocity_mode #(
	parameter int STANDSTILL_CYCLES = 1048576
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic step_pulse,
	input wire logic [3:0] ustep_shift,
	input wire logic [19:0] quiet_pwm_interval_threshold,
	input wire logic [19:0] high_velocity_interval_threshold,
	input wire logic [19:0] adaptive_current_interval_threshold,
	input wire logic small_hysteresis,
	input wire logic quiet_pwm_configured,
	input wire logic adaptive_current_configured,
	input wire logic [4:0] run_current_scale,
	input wire logic [4:0] hold_current_scale,
	output logic [19:0] step_interval_measured,
	output logic standstill,
	output logic quiet_pwm_active,
	output logic adaptive_current_active,
	output logic high_velocity_active,
	output logic [4:0] current_scale
);
	// ustep_shift: log2 of 256 / selected microstep resolution (0..8)

	// Standstill count must fit the saturating interval counter
	initial begin
		if (STANDSTILL_CYCLES < 2 || STANDSTILL_CYCLES > 1048576)
			$error("STANDSTILL_CYCLES out of range");
	end

	// Interval width fixed by the threshold ports
	initial begin
		if (vtm_pkg::INTERVAL_W != 20)
			$error("interval width does not match threshold ports");
	end

	// ***********************************************
	// Interval measurement
	// ***********************************************
	logic [20:0] count;
	logic [20:0] scaled;
	logic update;
	logic saturate;

	// Counting one step of coarse resolution equals 2^shift fine steps
	always_comb begin
		scaled = count >> ustep_shift;
	end

	assign saturate = (count == 21'(STANDSTILL_CYCLES - 1)) && !step_pulse;

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			count <= '0;
		else if (step_pulse)
			count <= 21'h000001;
		else if (count != 21'(STANDSTILL_CYCLES))
			count <= count + 21'h000001;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			step_interval_measured <= vtm_pkg::INTERVAL_MAX;
		else if (step_pulse)
			step_interval_measured <= (scaled > 21'(vtm_pkg::INTERVAL_MAX)) ?
				vtm_pkg::INTERVAL_MAX : scaled[19:0];
		else if (saturate)
			step_interval_measured <= vtm_pkg::INTERVAL_MAX;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			standstill <= 1'b1;
		else if (step_pulse)
			standstill <= 1'b0;
		else if (saturate)
			standstill <= 1'b1;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			update <= 1'b0;
		else
			update <= step_pulse | saturate;
	end

	// ***********************************************
	// Threshold comparison with hysteresis
	// ***********************************************
	logic [19:0] hyst;
	logic [20:0] upper_lim;
	logic [19:0] thr [3];
	logic [2:0] slow;

	// Fast side needs interval plus hysteresis below threshold
	// Band between the two switch points holds the last result
	always_comb begin
		hyst = small_hysteresis ? (step_interval_measured >> vtm_pkg::HYST_SHIFT_FINE) :
			(step_interval_measured >> vtm_pkg::HYST_SHIFT_COARSE);
		upper_lim = {1'b0, step_interval_measured} + {1'b0, hyst};
	end

	assign thr[0] = quiet_pwm_interval_threshold;
	assign thr[1] = high_velocity_interval_threshold;
	assign thr[2] = adaptive_current_interval_threshold;

	// slow[i]: interval at or above threshold, i.e. velocity at or below limit
	generate
		for (genvar i = 0; i < 3; i++) begin : g_cmp
			always_ff @(posedge clk or posedge reset) begin
				if (reset)
					slow[i] <= 1'b1;
				else if (update) begin
					if (step_interval_measured >= thr[i])
						slow[i] <= 1'b1;
					else if (upper_lim < {1'b0, thr[i]})
						slow[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// ***********************************************
	// Mode outputs
	// ***********************************************
	logic in_adaptive_band;
	logic fast_high;
	// High velocity region: interval below threshold, taken with hysteresis
	assign fast_high = !slow[1];
	// Adaptive band: between high and adaptive thresholds, both ends included
	assign in_adaptive_band = !fast_high && (!slow[2] || step_interval_measured == thr[2]);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			quiet_pwm_active <= 1'b0;
			adaptive_current_active <= 1'b0;
			high_velocity_active <= 1'b0;
		end else begin
			high_velocity_active <= fast_high;
			adaptive_current_active <= adaptive_current_configured && in_adaptive_band
				&& !standstill;
			quiet_pwm_active <= quiet_pwm_configured && slow[0] && !in_adaptive_band
				&& !fast_high;
		end
	end

	// ***********************************************
	// Current selection
	// ***********************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			current_scale <= '0;
		else
			current_scale <= standstill ? hold_current_scale : run_current_scale;
	end

	// ***********************************************
	// Checks
	// ***********************************************
	// Measurement and standstill
	chk_stst_after_step: assert property (@(posedge clk) disable iff (reset)
		step_pulse |=> !standstill) else $error("standstill not cleared by step");

	chk_sat_value: assert property (@(posedge clk) disable iff (reset)
		saturate |=> step_interval_measured == vtm_pkg::INTERVAL_MAX && standstill)
		else $error("no saturation at standstill");

	chk_cnt_stop: assert property (@(posedge clk) disable iff (reset)
		count <= 21'(STANDSTILL_CYCLES)) else $error("interval counter ran past stop");

	chk_interval_norm: assert property (@(posedge clk) disable iff (reset)
		step_pulse && scaled <= 21'(vtm_pkg::INTERVAL_MAX)
		|=> {1'b0, step_interval_measured} == $past(scaled))
		else $error("interval not normalised");

	// Threshold comparisons
	chk_cmp_hold: assert property (@(posedge clk) disable iff (reset)
		!update |=> $stable(slow)) else $error("compare changed without update");

	chk_slow_set: assert property (@(posedge clk) disable iff (reset)
		update && step_interval_measured >= thr[0] |=> slow[0])
		else $error("compare result not set");

	chk_fast_set: assert property (@(posedge clk) disable iff (reset)
		update && upper_lim < {1'b0, thr[1]} |=> !slow[1])
		else $error("fast result not set beyond hysteresis");

	chk_hyst_hold: assert property (@(posedge clk) disable iff (reset)
		update && step_interval_measured < thr[1] && upper_lim >= {1'b0, thr[1]}
		|=> $stable(slow[1]))
		else $error("hysteresis band not held");

	// Current and mode outputs
	chk_cur_sel: assert property (@(posedge clk) disable iff (reset)
		standstill && $stable(hold_current_scale) |=> current_scale == $past(hold_current_scale))
		else $error("hold current not applied");

	chk_run_cur: assert property (@(posedge clk) disable iff (reset)
		!standstill |=> current_scale == $past(run_current_scale))
		else $error("run current not applied");

	chk_band_pwm: assert property (@(posedge clk) disable iff (reset)
		adaptive_current_active |-> !quiet_pwm_active)
		else $error("voltage PWM active in adaptive band");

	chk_high_excl: assert property (@(posedge clk) disable iff (reset)
		high_velocity_active |-> !quiet_pwm_active && !adaptive_current_active)
		else $error("other mode active at high velocity");

	chk_high_mode: assert property (@(posedge clk) disable iff (reset)
		!slow[1] |=> high_velocity_active) else $error("high velocity not flagged");

	// ***********************************************
	// Covers
	// ***********************************************
	cov_stst: cover property (@(posedge clk) disable iff (reset) saturate);
	cov_high: cover property (@(posedge clk) disable iff (reset) $rose(high_velocity_active));
	cov_adapt: cover property (@(posedge clk) disable iff (reset) $rose(adaptive_current_active));
	cov_quiet: cover property (@(posedge clk) disable iff (reset) $fell(quiet_pwm_active));
	cov_band: cover property (@(posedge clk) disable iff (reset)
		update && step_interval_measured < thr[0] && upper_lim >= {1'b0, thr[0]});
endmodule
`default_nettype wire

// *** sim/vtm_step_source.sv ***
// Step pulse source standing in for the external step input
`default_nettype none
module vtm_step_source (
	input wire logic clk,
	output logic step_pulse
);
	timeunit 1ns;
	timeprecision 100ps;
	initial step_pulse = 1'b0;
	// One-cycle pulses, gap counted from pulse start to pulse start
	task automatic burst(input int gap, input int n);
		repeat (n) begin
			repeat (gap - 1) @(posedge clk);
			#1 step_pulse = 1'b1;
			@(posedge clk);
			#1 step_pulse = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

// *** sim/vtm_velocity_mode_bench.sv ***
// Bench for the velocity threshold mode select block
`default_nettype none
module vtm_velocity_mode_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, reset = 1'b1, hyst = 1'b0, step, stst, q_act, a_act, h_act;
	logic [3:0] shift = 4'h0;
	logic [19:0] thr_q = 20'h00014, thr_h = 20'h0000A, thr_a = 20'h0001E, interval;
	logic [4:0] cur;
	int miscompares = 0, n_checks = 0;
	vtm_step_source vtm_step_source_i (.clk(clk), .step_pulse(step));
	vtm_velocity_mode #(.STANDSTILL_CYCLES(512)) vtm_velocity_mode_i (
		.clk(clk), .reset(reset), .step_pulse(step), .ustep_shift(shift),
		.quiet_pwm_interval_threshold(thr_q), .high_velocity_interval_threshold(thr_h),
		.adaptive_current_interval_threshold(thr_a), .small_hysteresis(hyst),
		.quiet_pwm_configured(1'b1), .adaptive_current_configured(1'b1),
		.run_current_scale(5'h1A), .hold_current_scale(5'h05),
		.step_interval_measured(interval), .standstill(stst), .quiet_pwm_active(q_act),
		.adaptive_current_active(a_act), .high_velocity_active(h_act), .current_scale(cur));
	// ************************************
	// Checking, stimulus and closing tasks
	// ************************************
	task automatic check(input string what, input logic [19:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic modes(input logic q, a, h);
		check("quiet", 20'(q_act), 20'(q));
		check("adaptive", 20'(a_act), 20'(a));
		check("high", 20'(h_act), 20'(h));
	endtask
	task automatic run(input int gap);
		vtm_step_source_i.burst(gap, 3);
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic close_out;
		if (miscompares == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ************************************
	// Clock, watchdog and tests
	// ************************************
	initial forever #4 clk = ~clk;
	initial begin
		#400000;
		miscompares++;
		close_out;
	end
	initial begin
		repeat (8) @(posedge clk);
		#1 reset = 1'b0;
		run(40);
		modes(1'b1, 1'b0, 1'b0);
		check("standstill", 20'(stst), 20'h00000);
		check("current", 20'(cur), 20'h0001A);
		run(20);
		modes(1'b0, 1'b1, 1'b0);
		run(5);
		modes(1'b0, 1'b0, 1'b1);
		shift = 4'h1;
		run(40);
		modes(1'b0, 1'b1, 1'b0);
		shift = 4'h0;
		// Quiet velocity kept below adaptive one: adaptive band disabled here
		thr_q = 20'h00064;
		thr_h = 20'h00000;
		thr_a = 20'h00000;
		for (int i = 0; i < 2; i++) begin
			hyst = i[0];
			run(200);
			check("quiet slow", 20'(q_act), 20'h00001);
			run(95);
			check("quiet hyst", 20'(q_act), 20'(1 - i));
		end
		repeat (490) @(posedge clk);
		check("early standstill", 20'(stst), 20'h00000);
		repeat (30) @(posedge clk);
		check("standstill", 20'(stst), 20'h00001);
		check("interval", interval, 20'hFFFFF);
		check("hold current", 20'(cur), 20'h00005);
		close_out;
	end
endmodule
`default_nettype wire
